//--- verilog/ser_pkg.sv
package ser_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned CMD_W  = 4;
  localparam int unsigned LIVE_W = 6;

  // Host command codes, one per register access or action.
  typedef enum logic [3:0] {
    SER_CMD_OPER_COND_RD  = 4'h0,
    SER_CMD_OPER_MASK_WR  = 4'h1,
    SER_CMD_OPER_MASK_RD  = 4'h2,
    SER_CMD_OPER_EVENT_RD = 4'h3,
    SER_CMD_PRESET        = 4'h4,
    SER_CMD_QUES_EVENT_RD = 4'h5,
    SER_CMD_QUES_COND_RD  = 4'h6,
    SER_CMD_QUES_MASK_WR  = 4'h7,
    SER_CMD_QUES_MASK_RD  = 4'h8
  } ser_cmd_t;

  // Field positions of the operation group.
  localparam int unsigned OPER_CC_BIT = 10;
  localparam int unsigned OPER_CV_BIT = 8;

  // Field positions of the questionable group.
  localparam int unsigned QUES_CE_BIT = 13;
  localparam int unsigned QUES_VE_BIT = 12;
  localparam int unsigned QUES_CM_BIT = 1;
  localparam int unsigned QUES_VM_BIT = 0;

  // Writable operation mask bits: weights 1, 32, 256 and 1024, total 1313.
  localparam logic [15:0] OPER_MASK_BITS = 16'h0521;
  // Questionable bits that are latched into the event register.
  localparam logic [15:0] QUES_LATCH_BITS = 16'h3000;
  // Questionable bits that exist at all; every other position reads zero.
  localparam logic [15:0] QUES_MASK_BITS = 16'h3003;

  // Index of each live input inside the synchronised vector.
  localparam int unsigned LIVE_CC = 0;
  localparam int unsigned LIVE_CV = 1;
  localparam int unsigned LIVE_CE = 2;
  localparam int unsigned LIVE_VE = 3;
  localparam int unsigned LIVE_CM = 4;
  localparam int unsigned LIVE_VM = 5;

  // Positions of the summary flags in the status byte.
  localparam int unsigned STB_OPER_BIT = 7;
  localparam int unsigned STB_QUES_BIT = 3;

  localparam logic [15:0] RESET_MASK  = 16'h0000;
  localparam logic [15:0] RESET_EVENT = 16'h0000;
  localparam logic [15:0] RESET_COND  = 16'h0000;

  typedef struct packed {
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [5:0]  prev_live;
    logic [15:0] oper_cond;
    logic [15:0] ques_cond;
    logic [15:0] operation_event_latch;
    logic [15:0] questionable_event_latch;
    logic [15:0] operation_event_mask;
    logic [15:0] questionable_event_mask;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        oper_summary;
    logic        ques_summary;
  } ser_state_t;

endpackage : ser_pkg

//--- verilog/ser_status_event_reporting.sv
// Function
// - Operation mask gates operation events onto status byte bit 7.
// - Operation summary is OR of masked operation event bits.
// - Operation mask takes weights 1, 32, 256, 1024; reads return it.
// - Operation event register is read-only and latches rising edges until read.
// - Reading operation events returns the value, then clears it.
// - Preset command zeroes both condition registers.
// - Questionable events latch only bits 13 and 12.
// - Questionable mode bits 1 and 0 are never latched, only live.
// - Reading questionable events returns the value, then clears it.
// - Questionable layout: 13 current error, 12 voltage error, 1, 0 modes.
// - Questionable condition register shows live unlatched state; after a preset it reads zero until a pin moves.
// - Both mode bits may be set together while output settles.
// - Questionable mask gates questionable events onto status byte bit 3.
// - Questionable summary is OR of masked questionable event bits.
// - Questionable mask query returns the stored mask.
// - Operation events read zero after a read until a new rising edge.
// - Operation registers: constant current bit 10, constant voltage bit 8.
// - Operation condition register shows live unlatched state; after a preset it reads zero until a pin moves.
`timescale 1ns/1ps
`default_nettype none

module ser_status_event_reporting (
  input  wire logic        ref_clk_i,                // 200 MHz clock
  input  wire logic        rstn_i,                   // Synchronous reset, active low
  input  wire logic        cmd_valid_i,              // Command strobe
  input  wire logic [3:0]  cmd_code_i,               // Command code
  input  wire logic [15:0] cmd_data_i,               // Write data for mask writes
  input  wire logic        constant_current_flag_i,  // Live constant current pin
  input  wire logic        constant_voltage_flag_i,  // Live constant voltage pin
  input  wire logic        current_error_flag_i,     // Live current error pin
  input  wire logic        voltage_error_flag_i,     // Live voltage error pin
  input  wire logic        current_mode_flag_i,      // Live current mode pin
  input  wire logic        voltage_mode_flag_i,      // Live voltage mode pin
  output logic             rsp_valid_o,              // Read answer strobe
  output logic [15:0]      rsp_data_o,               // Read answer data
  output logic             oper_summary_o,           // Status byte bit 7
  output logic             ques_summary_o            // Status byte bit 3
);

  ser_pkg::ser_state_t st;
  ser_pkg::ser_state_t next_st;

  logic [5:0]  live_pins;
  logic [15:0] oper_live;
  logic [15:0] ques_live;
  logic [15:0] oper_rise;
  logic [15:0] ques_rise;
  logic        is_preset;
  logic        rd_oper_evt;
  logic        rd_ques_evt;

  // Operation positions that carry a live condition; the checks below use it.
  localparam logic [15:0] OPER_LIVE_BITS = (16'h0001 << ser_pkg::OPER_CC_BIT)
                                         | (16'h0001 << ser_pkg::OPER_CV_BIT);

  function automatic logic cmd_is(input logic [3:0] code, input ser_pkg::ser_cmd_t which);
    cmd_is = cmd_valid_i && (code == which);
  endfunction : cmd_is

  function automatic logic [15:0] rise_of(input logic [15:0] now_v,
                                          input logic [15:0] old_v);
    rise_of = now_v & ~old_v;
  endfunction : rise_of

  assign live_pins = {voltage_mode_flag_i, current_mode_flag_i, voltage_error_flag_i,
                      current_error_flag_i, constant_voltage_flag_i,
                      constant_current_flag_i};

  assign is_preset   = cmd_is(cmd_code_i, ser_pkg::SER_CMD_PRESET);
  assign rd_oper_evt = cmd_is(cmd_code_i, ser_pkg::SER_CMD_OPER_EVENT_RD);
  assign rd_ques_evt = cmd_is(cmd_code_i, ser_pkg::SER_CMD_QUES_EVENT_RD);

  // Live state mapped onto the register layouts.
  always_comb begin
    oper_live = 16'h0000;
    ques_live = 16'h0000;
    oper_live[ser_pkg::OPER_CC_BIT] = st.sync2[ser_pkg::LIVE_CC];
    oper_live[ser_pkg::OPER_CV_BIT] = st.sync2[ser_pkg::LIVE_CV];
    ques_live[ser_pkg::QUES_CE_BIT] = st.sync2[ser_pkg::LIVE_CE];
    ques_live[ser_pkg::QUES_VE_BIT] = st.sync2[ser_pkg::LIVE_VE];
    ques_live[ser_pkg::QUES_CM_BIT] = st.sync2[ser_pkg::LIVE_CM];
    ques_live[ser_pkg::QUES_VM_BIT] = st.sync2[ser_pkg::LIVE_VM];
  end

  always_comb begin
    next_st = st;
    oper_rise = 16'h0000;
    ques_rise = 16'h0000;

    next_st.sync1     = live_pins;
    next_st.sync2     = st.sync1;
    next_st.prev_live = st.sync2;
    next_st.rsp_valid = 1'b0;

    // Conditions track the pins; after a preset they stay zero until a pin moves.
    if (is_preset) begin
      next_st.oper_cond = ser_pkg::RESET_COND;
      next_st.ques_cond = ser_pkg::RESET_COND;
    end else if (st.sync2 != st.prev_live) begin
      next_st.oper_cond = oper_live;
      next_st.ques_cond = ques_live;
    end

    oper_rise = rise_of(next_st.oper_cond, st.oper_cond);
    ques_rise = rise_of(next_st.ques_cond, st.ques_cond) & ser_pkg::QUES_LATCH_BITS;

    // A read clears the latch, but an edge in the same cycle survives.
    if (rd_oper_evt) begin
      next_st.operation_event_latch = oper_rise;
    end else begin
      next_st.operation_event_latch = st.operation_event_latch | oper_rise;
    end
    if (rd_ques_evt) begin
      next_st.questionable_event_latch = ques_rise;
    end else begin
      next_st.questionable_event_latch = st.questionable_event_latch | ques_rise;
    end

    if (cmd_valid_i) begin
      case (cmd_code_i)
        ser_pkg::SER_CMD_OPER_COND_RD: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = st.oper_cond;
        end
        ser_pkg::SER_CMD_OPER_MASK_WR: begin
          next_st.operation_event_mask = cmd_data_i & ser_pkg::OPER_MASK_BITS;
        end
        ser_pkg::SER_CMD_OPER_MASK_RD: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = st.operation_event_mask;
        end
        ser_pkg::SER_CMD_OPER_EVENT_RD: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = st.operation_event_latch;
        end
        ser_pkg::SER_CMD_QUES_EVENT_RD: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = st.questionable_event_latch;
        end
        ser_pkg::SER_CMD_QUES_COND_RD: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = st.ques_cond;
        end
        ser_pkg::SER_CMD_QUES_MASK_WR: begin
          // Unused positions are dropped so that they always read back as zero.
          next_st.questionable_event_mask = cmd_data_i & ser_pkg::QUES_MASK_BITS;
        end
        ser_pkg::SER_CMD_QUES_MASK_RD: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = st.questionable_event_mask;
        end
        default: begin
          next_st.rsp_valid = 1'b0;
        end
      endcase
    end

    // Summaries are computed from the next values so they match the registers.
    next_st.oper_summary = |(next_st.operation_event_latch
                             & next_st.operation_event_mask);
    next_st.ques_summary = |(next_st.questionable_event_latch
                             & next_st.questionable_event_mask);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rsp_valid_o    = st.rsp_valid;
  assign rsp_data_o     = st.rsp_data;
  assign oper_summary_o = st.oper_summary;
  assign ques_summary_o = st.ques_summary;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  oper_summary_a: assert property (
    oper_summary_o == |(st.operation_event_latch & st.operation_event_mask))
    else $error("operation summary differs from masked events");

  ques_summary_a: assert property (
    ques_summary_o == |(st.questionable_event_latch & st.questionable_event_mask))
    else $error("questionable summary differs from masked events");

  oper_mask_a: assert property (
    cmd_valid_i && cmd_code_i == ser_pkg::SER_CMD_OPER_MASK_WR
    |=> st.operation_event_mask == ($past(cmd_data_i) & ser_pkg::OPER_MASK_BITS))
    else $error("operation mask write did not land");

  oper_mask_rd_a: assert property (
    cmd_valid_i && cmd_code_i == ser_pkg::SER_CMD_OPER_MASK_RD
    |=> rsp_valid_o && rsp_data_o == $past(st.operation_event_mask))
    else $error("operation mask read back wrong");

  ques_mask_a: assert property (
    cmd_valid_i && cmd_code_i == ser_pkg::SER_CMD_QUES_MASK_WR
    |=> st.questionable_event_mask == ($past(cmd_data_i) & ser_pkg::QUES_MASK_BITS))
    else $error("questionable mask write did not land");

  ques_mask_rd_a: assert property (
    cmd_valid_i && cmd_code_i == ser_pkg::SER_CMD_QUES_MASK_RD
    |=> rsp_valid_o && rsp_data_o == $past(st.questionable_event_mask))
    else $error("questionable mask read back wrong");

  oper_cond_rd_a: assert property (
    cmd_valid_i && cmd_code_i == ser_pkg::SER_CMD_OPER_COND_RD
    |=> rsp_valid_o && rsp_data_o == $past(st.oper_cond))
    else $error("operation condition read wrong");

  ques_cond_rd_a: assert property (
    cmd_valid_i && cmd_code_i == ser_pkg::SER_CMD_QUES_COND_RD
    |=> rsp_valid_o && rsp_data_o == $past(st.ques_cond))
    else $error("questionable condition read wrong");

  no_write_rsp_a: assert property (
    (cmd_valid_i && cmd_code_i == ser_pkg::SER_CMD_OPER_MASK_WR)
    || (cmd_valid_i && cmd_code_i == ser_pkg::SER_CMD_QUES_MASK_WR) || is_preset
    |=> !rsp_valid_o)
    else $error("write or preset produced a read answer");

  rsp_only_read_a: assert property (
    !cmd_valid_i |=> !rsp_valid_o)
    else $error("read answer without a command");

  oper_read_a: assert property (
    rd_oper_evt |=> rsp_valid_o && rsp_data_o == $past(st.operation_event_latch))
    else $error("operation event read returned wrong value");

  oper_clear_a: assert property (
    rd_oper_evt && oper_rise == 16'h0000 |=> st.operation_event_latch == 16'h0000)
    else $error("operation event not cleared by read");

  oper_hold_a: assert property (
    !rd_oper_evt |=> (st.operation_event_latch & $past(st.operation_event_latch))
                     == $past(st.operation_event_latch))
    else $error("operation event bit lost without read");

  oper_set_a: assert property (
    oper_rise != 16'h0000
    |=> (st.operation_event_latch & $past(oper_rise)) == $past(oper_rise))
    else $error("operation condition edge not latched");

  oper_layout_a: assert property (
    ((st.oper_cond | st.operation_event_latch) & ~OPER_LIVE_BITS) == 16'h0000)
    else $error("operation register shows an unused bit");

  preset_a: assert property (
    is_preset |=> st.oper_cond == 16'h0000 && st.ques_cond == 16'h0000)
    else $error("preset did not zero condition registers");

  preset_hold_a: assert property (
    is_preset ##1 (!is_preset && st.sync2 == st.prev_live)
    |=> st.oper_cond == 16'h0000 && st.ques_cond == 16'h0000)
    else $error("condition returned after preset without a pin change");

  ques_latch_a: assert property (
    (st.questionable_event_latch & ~ser_pkg::QUES_LATCH_BITS) == 16'h0000)
    else $error("questionable event latched an unlatched bit");

  ques_clear_a: assert property (
    rd_ques_evt |=> rsp_valid_o && rsp_data_o == $past(st.questionable_event_latch)
                    && st.questionable_event_latch == $past(ques_rise))
    else $error("questionable event read or clear wrong");

  ques_hold_a: assert property (
    !rd_ques_evt |=> (st.questionable_event_latch & $past(st.questionable_event_latch))
                     == $past(st.questionable_event_latch))
    else $error("questionable event bit lost without read");

  ques_set_a: assert property (
    ques_rise != 16'h0000
    |=> (st.questionable_event_latch & $past(ques_rise)) == $past(ques_rise))
    else $error("questionable condition edge not latched");

  ques_layout_a: assert property (
    ((st.ques_cond | st.questionable_event_mask) & ~ser_pkg::QUES_MASK_BITS) == 16'h0000)
    else $error("questionable register shows an unused bit");

  settle_modes_a: assert property (
    !is_preset && st.sync2 != st.prev_live && st.sync2[ser_pkg::LIVE_CM]
    && st.sync2[ser_pkg::LIVE_VM]
    |=> st.ques_cond[ser_pkg::QUES_CM_BIT] && st.ques_cond[ser_pkg::QUES_VM_BIT])
    else $error("settling modes not shown together");

  live_track_a: assert property (
    !is_preset && st.sync2 != st.prev_live |=> st.ques_cond == $past(ques_live)
                                               && st.oper_cond == $past(oper_live))
    else $error("condition register does not follow live state");

  // Covers mark the main scenarios: event read, summary rise, preset, settling, mask write.
  oper_event_c: cover property (rd_oper_evt && st.operation_event_latch != 16'h0000);
  ques_summary_c: cover property ($rose(ques_summary_o));
  preset_c: cover property (is_preset && st.oper_cond != 16'h0000);
  settling_c: cover property (st.ques_cond[1:0] == 2'b11);
  mask_write_c: cover property (cmd_valid_i && cmd_code_i == ser_pkg::SER_CMD_QUES_MASK_WR);

endmodule : ser_status_event_reporting

`default_nettype wire

//--- tb/ser_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module ser_host_model (
  input  wire logic        ref_clk_i,   // Bench clock
  input  wire logic        req_i,       // Command request from the bench
  input  wire logic [3:0]  code_i,      // Requested command code
  input  wire logic [15:0] data_i,      // Requested write data
  output var  logic        cmd_valid_o, // One-cycle command strobe
  output var  logic [3:0]  cmd_code_o,  // Command code to the device
  output var  logic [15:0] cmd_data_o   // Write data to the device
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = 4'h0;
    cmd_data_o  = 16'h0000;
  end

  // Unqualified cycles carry inverted code and data so stale values never look valid.
  always @(posedge ref_clk_i) begin
    cmd_valid_o <= req_i;
    cmd_code_o  <= req_i ? code_i : ~cmd_code_o;
    cmd_data_o  <= req_i ? data_i : ~cmd_data_o;
  end
endmodule : ser_host_model

`default_nettype wire

//--- tb/ser_status_event_reporting_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ser_status_event_reporting_tb;
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, req = 1'b0, osum, qsum, rsp_valid, cmd_valid;
  logic [3:0] code = 4'h0, cmd_code;
  logic [15:0] data = 16'h0000, cmd_data, rsp_data, v, om, qm, oev, qev, oc, qc;
  logic [5:0] pv = 6'h00;
  int errors = 0, total_checks = 0, seed = 50954, i;
  logic [3:0] rc[6] = '{4'h0, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8};

  initial forever #2.5 ref_clk_i = ~ref_clk_i;

  ser_host_model host (.ref_clk_i(ref_clk_i), .req_i(req), .code_i(code), .data_i(data),
    .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_data_o(cmd_data));

  ser_status_event_reporting uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_data_i(cmd_data),
    .constant_current_flag_i(pv[ser_pkg::LIVE_CC]), .constant_voltage_flag_i(pv[ser_pkg::LIVE_CV]),
    .current_error_flag_i(pv[ser_pkg::LIVE_CE]), .voltage_error_flag_i(pv[ser_pkg::LIVE_VE]),
    .current_mode_flag_i(pv[ser_pkg::LIVE_CM]), .voltage_mode_flag_i(pv[ser_pkg::LIVE_VM]),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .oper_summary_o(osum), .ques_summary_o(qsum));

  function automatic logic [15:0] oexp(input logic [5:0] p);
    oexp = 16'h0000;
    oexp[ser_pkg::OPER_CC_BIT] = p[ser_pkg::LIVE_CC];
    oexp[ser_pkg::OPER_CV_BIT] = p[ser_pkg::LIVE_CV];
  endfunction : oexp

  function automatic logic [15:0] qexp(input logic [5:0] p);
    qexp = 16'h0000;
    qexp[ser_pkg::QUES_CE_BIT] = p[ser_pkg::LIVE_CE];
    qexp[ser_pkg::QUES_VE_BIT] = p[ser_pkg::LIVE_VE];
    qexp[ser_pkg::QUES_CM_BIT] = p[ser_pkg::LIVE_CM];
    qexp[ser_pkg::QUES_VM_BIT] = p[ser_pkg::LIVE_VM];
  endfunction : qexp

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] c, input logic [15:0] d);
    @(posedge ref_clk_i);
    #1 req = 1'b1;
    code = c;
    data = d;
    @(posedge ref_clk_i);
    #1 req = 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] c, output logic [15:0] r);
    int n;
    wr(c, 16'h0000);
    r = 16'hxxxx;
    for (n = 0; n < 8; n++) begin
      @(posedge ref_clk_i);
      #1;
      if (rsp_valid === 1'b1) begin
        r = rsp_data;
        break;
      end
    end
  endtask : rd

  task automatic setp(input logic [5:0] p);
    @(posedge ref_clk_i);
    #1 pv = p;
    repeat (6) @(posedge ref_clk_i);
    #1;
  endtask : setp

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    errors++;
    $display("watchdog expired");
    wrap_up;
  end

  initial begin
    repeat (6) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    for (i = 0; i < 6; i++) begin
      rd(rc[i], v);
      chk("reset read", 16'h0000, v);
    end
    $display("test reset done");
    wr(4'h1, 16'h0521);
    rd(4'h2, v);
    chk("oper mask max", 16'h0521, v);
    wr(4'h7, 16'hffff);
    rd(4'h8, v);
    chk("ques mask unused bits", ser_pkg::QUES_MASK_BITS, v);
    qm = 16'($random(seed)) & ser_pkg::QUES_MASK_BITS;
    wr(4'h7, qm);
    wr(4'h9, 16'hffff);
    rd(4'h2, v);
    chk("oper mask after unknown code", 16'h0521, v);
    rd(4'h8, v);
    chk("ques mask", qm, v);
    $display("test masks done");
    wr(4'h1, 16'h0400);
    setp(6'b000011);
    rd(4'h0, v);
    chk("oper cond", 16'h0500, v);
    chk("oper summary set", 16'h0001, {15'h0, osum});
    rd(4'h3, v);
    chk("oper event", 16'h0500, v);
    #5;
    chk("oper summary clear", 16'h0000, {15'h0, osum});
    rd(4'h3, v);
    chk("oper event reread", 16'h0000, v);
    setp(6'b000000);
    setp(6'b000001);
    setp(6'b000000);
    rd(4'h0, v);
    chk("oper cond low", 16'h0000, v);
    rd(4'h3, v);
    chk("oper event held", 16'h0400, v);
    $display("test operation done");
    wr(4'h7, 16'h0003);
    setp(6'b111100);
    rd(4'h6, v);
    chk("ques cond all", 16'h3003, v);
    chk("ques summary modes", 16'h0000, {15'h0, qsum});
    wr(4'h7, 16'h1000);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk("ques summary set", 16'h0001, {15'h0, qsum});
    rd(4'h5, v);
    chk("ques event", 16'h3000, v);
    rd(4'h5, v);
    chk("ques event reread", 16'h0000, v);
    chk("ques summary clear", 16'h0000, {15'h0, qsum});
    $display("test questionable done");
    wr(4'h4, 16'h0000);
    repeat (2) @(posedge ref_clk_i);
    rd(4'h0, v);
    chk("preset oper cond", 16'h0000, v);
    rd(4'h6, v);
    chk("preset ques cond", 16'h0000, v);
    $display("test preset done");
    setp(6'b000000);
    rd(4'h3, v);
    rd(4'h5, v);
    oc = 16'h0000;
    qc = 16'h0000;
    for (i = 0; i < 24; i++) begin
      om = 16'($random(seed)) & ser_pkg::OPER_MASK_BITS;
      qm = 16'($random(seed)) & ser_pkg::QUES_MASK_BITS;
      wr(4'h1, om);
      wr(4'h7, qm);
      setp(6'($random(seed)));
      oev = oexp(pv) & ~oc;
      qev = qexp(pv) & ~qc & ser_pkg::QUES_LATCH_BITS;
      chk("rand oper summary", {15'h0, |(oev & om)}, {15'h0, osum});
      chk("rand ques summary", {15'h0, |(qev & qm)}, {15'h0, qsum});
      rd(4'h0, v);
      chk("rand oper cond", oexp(pv), v);
      rd(4'h6, v);
      chk("rand ques cond", qexp(pv), v);
      rd(4'h3, v);
      chk("rand oper event", oev, v);
      rd(4'h5, v);
      chk("rand ques event", qev, v);
      oc = oexp(pv);
      qc = qexp(pv);
    end
    $display("test random done");
    wrap_up;
  end
endmodule : ser_status_event_reporting_tb

`default_nettype wire
